// file: pbt_pkg.sv
// package: register map, field layout and codes of the binning and tap output stage
package pbt_pkg;
  // datapath sizes
  localparam int PIX_W    = 12;    // sensor pixel width
  localparam int SUM_W    = 16;    // room for a four by four sum of full-scale pixels
  localparam int MAX_TAPS = 10;    // widest tap geometry
  localparam int COL_W    = 14;    // index of a binned column
  localparam int COL_MAX  = 16384; // binned columns one row buffer holds
  localparam int FAC_W    = 3;     // width of a binning factor field
  localparam int CFG_W    = 4;     // width of pixel width and tap count fields
  // register byte addresses
  localparam logic [7:0] REG_BIN_SEL = 8'h00;
  localparam logic [7:0] REG_BIN_CFG = 8'h04;
  localparam logic [7:0] REG_FORMAT  = 8'h08;
  localparam logic [7:0] REG_LINK    = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  // field positions
  localparam int F_HMODE = 0;  // bin cfg: horizontal mode
  localparam int F_VMODE = 1;  // bin cfg: vertical mode
  localparam int F_HFAC  = 4;  // bin cfg: horizontal factor
  localparam int F_VFAC  = 8;  // bin cfg: vertical factor
  localparam int F_BITS  = 0;  // format: pixel width
  localparam int F_TAPS  = 8;  // format: tap count
  localparam int F_FVAL  = 0;  // status: frame valid
  localparam int F_LVAL  = 1;  // status: line valid
  localparam int F_TOTH  = 8;  // status: combined horizontal factor
  localparam int F_TOTV  = 12; // status: combined vertical factor
  localparam int F_FCNT  = 16; // status: frames accepted
  // codes
  localparam logic ENG_SENSOR = 1'b0;
  localparam logic ENG_LOGIC  = 1'b1;
  localparam logic MODE_SUM   = 1'b0;
  localparam logic MODE_AVG   = 1'b1;
  localparam logic RATE_85    = 1'b0;
  localparam logic RATE_65    = 1'b1;
  localparam logic [FAC_W-1:0] FAC_1 = 3'h1;
  localparam logic [FAC_W-1:0] FAC_2 = 3'h2;
  localparam logic [FAC_W-1:0] FAC_3 = 3'h3;
  localparam logic [FAC_W-1:0] FAC_4 = 3'h4;
  localparam logic [CFG_W-1:0] BITS_8  = 4'h8;
  localparam logic [CFG_W-1:0] BITS_10 = 4'ha;
  localparam logic [CFG_W-1:0] BITS_12 = 4'hc;
  localparam logic [CFG_W-1:0] TAP_2  = 4'h2;
  localparam logic [CFG_W-1:0] TAP_4  = 4'h4;
  localparam logic [CFG_W-1:0] TAP_8  = 4'h8;
  localparam logic [CFG_W-1:0] TAP_10 = 4'ha;
endpackage

// file: pbt_tap_packer.sv
// tap packer: groups binned pixels into interleaved tap words, one word per link clock edge
`timescale 1ns/100ps
module pbt_tap_packer import pbt_pkg::*; (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // configuration and link timing
  input  wire logic [CFG_W-1:0]            taps,
  input  wire logic                        link_tick,
  // binned pixels in
  input  wire logic                        px_valid,
  input  wire logic [PIX_W-1:0]            px_data,
  input  wire logic                        px_eol,
  input  wire logic                        px_eof,
  output logic                             px_ready,
  // link out
  output logic [MAX_TAPS*PIX_W-1:0]        tap_data,
  output logic                             tap_dval,
  output logic                             tap_lval,
  output logic                             tap_fval
);
  logic [PIX_W-1:0] grp [MAX_TAPS]; // group being filled
  logic [CFG_W-1:0] fill;           // next lane to fill
  logic             full;           // group waits for a link edge
  logic             grp_eol;        // group ends a line
  logic             grp_eof;        // group ends a frame
  logic             in_line;        // line still open after last word
  logic             in_frame;       // frame open
  logic             line_gap;       // one idle link cycle owed after a line end
  logic             take;           // pixel accepted
  logic             send;           // word leaves on this link edge

  assign px_ready = !full;
  assign take     = px_valid && px_ready;
  assign send     = link_tick && full && !line_gap;

  // group fill control; a short line end closes a partial group
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fill    <= '0;
      full    <= 1'b0;
      grp_eol <= 1'b0;
      grp_eof <= 1'b0;
    end else if (send) begin
      fill    <= '0;
      full    <= 1'b0;
      grp_eol <= 1'b0;
      grp_eof <= 1'b0;
    end else if (take) begin
      fill    <= fill + 4'h1;
      full    <= (fill + 4'h1 >= taps) || px_eol || px_eof;
      grp_eol <= px_eol;
      grp_eof <= px_eof;
    end
  end

  // lanes fill from zero upward, the next group lands on the next word
  // one process owns the whole group, so no lane has a second driver
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < MAX_TAPS; i++) begin
        grp[i] <= '0;
      end
    end else begin
      for (int i = 0; i < MAX_TAPS; i++) begin
        if (send) begin
          grp[i] <= '0;                            // unused lanes of the next word read zero
        end else if (take && fill == CFG_W'(i)) begin
          grp[i] <= px_data;
        end
      end
    end
  end

  // one word per link edge; an idle edge puts zeros on every lane
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tap_data <= '0;
    end else if (link_tick) begin
      for (int i = 0; i < MAX_TAPS; i++) begin
        tap_data[i*PIX_W +: PIX_W] <= send ? grp[i] : '0;
      end
    end
  end

  // line and frame framing; a line end forces one link cycle with line valid low,
  // otherwise back-to-back lines would merge into one long line at the grabber
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_line  <= 1'b0;
      in_frame <= 1'b0;
      line_gap <= 1'b0;
    end else if (send) begin
      in_line  <= !grp_eol && !grp_eof;
      in_frame <= !grp_eof;
      line_gap <= grp_eol || grp_eof;
    end else if (link_tick) begin
      line_gap <= 1'b0;
    end
  end

  // qualifiers stand for a whole link cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tap_dval <= 1'b0;
      tap_lval <= 1'b0;
      tap_fval <= 1'b0;
    end else if (link_tick) begin
      tap_dval <= send;
      tap_lval <= send || in_line;
      tap_fval <= send || in_frame;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  frame_nest_a: assert property (tap_dval |-> tap_lval && tap_fval)
    else $error("data valid outside line or frame");
  lane_zero_a: assert property (send && taps == TAP_2 |=> tap_data[MAX_TAPS*PIX_W-1:2*PIX_W] == '0)
    else $error("lane above tap count not zero");
  word_first_a: assert property (send |=>
    tap_data[PIX_W-1:0] == $past(grp[0]) && tap_data[2*PIX_W-1:PIX_W] == $past(grp[1]))
    else $error("first pixel not on lane zero");
  word_out_c: cover property (send && grp_eol);
endmodule

// file: pbt_binning_output.sv
// binning engine, pixel formatting and tap output stage of a monochrome camera
// What this block does
// - selector picks sensor or logic binning bank
// - horizontal sum adds adjacent pixels
// - horizontal average divides sum by count
// - vertical sum adds pixels of adjacent rows
// - vertical average divides sum by count
// - logic horizontal factor one, two or four
// - vertical factor: sensor 1/3, logic 1/2/4
// - sensor binning offers average only
// - sensor horizontal factor follows vertical factor
// - sensor horizontal mode follows vertical mode
// - sensor and logic factors multiply together
// - pixel width selectable as 8, 10, 12
// - tap count pixels per link cycle
// - tap geometry coded by its tap count
// - line pixels interleaved across active taps
// - link clock rate 85 or 65 MHz
`timescale 1ns/100ps
module pbt_binning_output import pbt_pkg::*; (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // register port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [31:0]                      reg_rdata,
  // sensor pixel stream
  input  wire logic [PIX_W-1:0]            pix_data,
  input  wire logic                        pix_valid,
  input  wire logic                        pix_eol,
  input  wire logic                        pix_eof,
  output logic                             in_ready,
  // sensor binning control
  output logic [FAC_W-1:0]                 sensor_bin_factor,
  output logic                             sensor_bin_average,
  // link
  input  wire logic                        link_clk,
  output logic                             link_clock_rate_select,
  output logic [MAX_TAPS*PIX_W-1:0]        tap_data,
  output logic                             tap_dval,
  output logic                             tap_lval,
  output logic                             tap_fval
);
  // configuration state
  logic             bin_sel;      // bank that configuration writes reach
  logic [FAC_W-1:0] sen_hf;       // sensor bank horizontal factor
  logic [FAC_W-1:0] sen_vf;       // sensor bank vertical factor
  logic             sen_hmode;    // sensor bank horizontal mode
  logic             sen_vmode;    // sensor bank vertical mode
  logic [FAC_W-1:0] log_hf;       // logic bank horizontal factor
  logic [FAC_W-1:0] log_vf;       // logic bank vertical factor
  logic             log_hmode;    // logic bank horizontal mode
  logic             log_vmode;    // logic bank vertical mode
  logic [CFG_W-1:0] pix_bits;     // transmitted pixel width
  logic [CFG_W-1:0] taps;         // tap geometry, coded by count
  logic [15:0]      frame_cnt;    // frames accepted
  // datapath state
  logic [1:0]       hcnt;         // pixel within horizontal group
  logic [1:0]       vrow;         // row within vertical group
  logic [COL_W-1:0] col;          // binned column
  logic [SUM_W-1:0] hacc;         // horizontal partial sum
  logic [SUM_W-1:0] rowmem [COL_MAX]; // vertical partial sums of one binned row
  logic             stg_valid;    // formatted pixel waits for packer
  logic [PIX_W-1:0] stg_data;
  logic             stg_eol;
  logic             stg_eof;
  logic             pk_ready;
  // link clock sampling
  logic             lk_s1;
  logic             lk_s2;
  logic             lk_s3;
  logic             link_tick;
  // combinational datapath
  logic             accept;
  logic             h_done;
  logic             v_last;
  logic             emit;
  logic [SUM_W-1:0] hsum;
  logic [SUM_W-1:0] vsum;
  logic [2:0]       avg_shift;
  logic             wr_sel;
  logic             wr_cfg;
  logic [FAC_W-1:0] w_hf;
  logic [FAC_W-1:0] w_vf;

  // factor legality per engine
  function automatic logic fac_log_ok(input logic [FAC_W-1:0] f);
    fac_log_ok = (f == FAC_1) || (f == FAC_2) || (f == FAC_4);
  endfunction
  function automatic logic fac_sen_ok(input logic [FAC_W-1:0] f);
    fac_sen_ok = (f == FAC_1) || (f == FAC_3);
  endfunction
  // logic factors are powers of two, so division is a shift
  function automatic logic [1:0] fac_lg2(input logic [FAC_W-1:0] f);
    fac_lg2 = (f == FAC_4) ? 2'h2 : (f == FAC_2) ? 2'h1 : 2'h0;
  endfunction
  // divide, scale to the selected width, clamp
  function automatic logic [PIX_W-1:0] fmt(input logic [SUM_W-1:0] s, input logic [2:0] sh,
                                           input logic [CFG_W-1:0] bits);
    logic [SUM_W-1:0] v;
    logic [SUM_W-1:0] mx;
    v   = s >> sh;
    v   = v >> (BITS_12 - bits);
    mx  = (SUM_W'(1) << bits) - SUM_W'(1);
    fmt = (v > mx) ? mx[PIX_W-1:0] : v[PIX_W-1:0];
  endfunction

  assign wr_sel = reg_wr && reg_addr == REG_BIN_SEL;
  assign wr_cfg = reg_wr && reg_addr == REG_BIN_CFG;
  assign w_hf   = reg_wdata[F_HFAC +: FAC_W];
  assign w_vf   = reg_wdata[F_VFAC +: FAC_W];

  // bank selector
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bin_sel <= ENG_LOGIC;
    end else if (wr_sel) begin
      bin_sel <= reg_wdata[0];
    end
  end

  // sensor bank: average only, horizontal settings follow vertical ones
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sen_hf    <= FAC_1;
      sen_vf    <= FAC_1;
      sen_hmode <= MODE_AVG;
      sen_vmode <= MODE_AVG;
    end else if (wr_cfg && bin_sel == ENG_SENSOR) begin
      if (fac_sen_ok(w_vf)) begin
        sen_vf <= w_vf;
        sen_hf <= w_vf;
      end
      sen_vmode <= MODE_AVG;
      sen_hmode <= MODE_AVG;
    end
  end

  // logic bank; an illegal factor leaves the old one standing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      log_hf    <= FAC_1;
      log_vf    <= FAC_1;
      log_hmode <= MODE_SUM;
      log_vmode <= MODE_SUM;
    end else if (wr_cfg && bin_sel == ENG_LOGIC) begin
      if (fac_log_ok(w_hf)) begin
        log_hf <= w_hf;
      end
      if (fac_log_ok(w_vf)) begin
        log_vf <= w_vf;
      end
      log_hmode <= reg_wdata[F_HMODE];
      log_vmode <= reg_wdata[F_VMODE];
    end
  end

  // pixel format and link settings; unknown codes are ignored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pix_bits               <= BITS_8;
      taps                   <= TAP_2;
      link_clock_rate_select <= RATE_85;
    end else if (reg_wr) begin
      if (reg_addr == REG_FORMAT) begin
        case (reg_wdata[F_BITS +: CFG_W])
          BITS_8, BITS_10, BITS_12: pix_bits <= reg_wdata[F_BITS +: CFG_W];
          default: pix_bits <= pix_bits;
        endcase
        case (reg_wdata[F_TAPS +: CFG_W])
          TAP_2, TAP_4, TAP_8, TAP_10: taps <= reg_wdata[F_TAPS +: CFG_W];
          default: taps <= taps;
        endcase
      end
      if (reg_addr == REG_LINK) begin
        link_clock_rate_select <= reg_wdata[0];
      end
    end
  end

  // sensor drives its own analog binning from the sensor bank
  assign sensor_bin_factor  = sen_vf;
  assign sensor_bin_average = sen_vmode;

  // read port: data stand in the cycle after the strobe only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_BIN_SEL: reg_rdata <= {31'h0, bin_sel};
        REG_BIN_CFG: reg_rdata <= (bin_sel == ENG_SENSOR)
          ? {21'h0, sen_vf, 1'b0, sen_hf, 2'h0, sen_vmode, sen_hmode}
          : {21'h0, log_vf, 1'b0, log_hf, 2'h0, log_vmode, log_hmode};
        REG_FORMAT:  reg_rdata <= {20'h0, taps, 4'h0, pix_bits};
        REG_LINK:    reg_rdata <= {31'h0, link_clock_rate_select};
        REG_STATUS:  reg_rdata <= {frame_cnt, CFG_W'(sen_vf * log_vf), CFG_W'(sen_hf * log_hf),
                                   6'h0, tap_lval, tap_fval};
        default:     reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // link clock crosses in through two flops; edges found past the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_s1 <= 1'b0;
      lk_s2 <= 1'b0;
      lk_s3 <= 1'b0;
    end else begin
      lk_s1 <= link_clk;
      lk_s2 <= lk_s1;
      lk_s3 <= lk_s2;
    end
  end
  assign link_tick = lk_s2 && !lk_s3;

  // binning datapath; a held stage stalls the sensor rather than drop pixels
  assign in_ready  = !stg_valid || pk_ready;
  assign accept    = pix_valid && in_ready;
  assign h_done    = accept && ({1'b0, hcnt} == log_hf - FAC_1);
  assign v_last    = {1'b0, vrow} == log_vf - FAC_1;
  assign emit      = h_done && v_last;
  assign hsum      = hacc + SUM_W'(pix_data);
  assign vsum      = ((vrow == 2'h0) ? '0 : rowmem[col]) + hsum;
  assign avg_shift = {1'b0, (log_hmode == MODE_AVG) ? fac_lg2(log_hf) : 2'h0}
                   + {1'b0, (log_vmode == MODE_AVG) ? fac_lg2(log_vf) : 2'h0};

  // horizontal grouping and row position
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hcnt <= '0;
      hacc <= '0;
      col  <= '0;
      vrow <= '0;
    end else if (accept) begin
      hcnt <= h_done ? 2'h0 : hcnt + 2'h1;
      hacc <= h_done ? '0 : hsum;
      if (pix_eol || pix_eof) begin
        col  <= '0;
        hcnt <= '0;
        hacc <= '0;
        vrow <= (v_last || pix_eof) ? 2'h0 : vrow + 2'h1;
      end else if (h_done) begin
        col <= col + COL_W'(1);
      end
    end
  end

  // partial vertical sums wait here until the last row of the group
  always_ff @(posedge clk) begin
    if (h_done && !v_last) begin
      rowmem[col] <= vsum;
    end
  end

  // output stage holds one formatted pixel for the packer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stg_valid <= 1'b0;
      stg_data  <= '0;
      stg_eol   <= 1'b0;
      stg_eof   <= 1'b0;
    end else if (in_ready) begin
      stg_valid <= emit;
      if (emit) begin
        stg_data <= fmt(vsum, avg_shift, pix_bits);
        stg_eol  <= pix_eol;
        stg_eof  <= pix_eof;
      end
    end
  end

  // frame counter for status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_cnt <= '0;
    end else if (accept && pix_eof) begin
      frame_cnt <= frame_cnt + 16'h1;
    end
  end

  pbt_tap_packer u_packer (
    .clk       (clk),
    .reset_n   (reset_n),
    .taps      (taps),
    .link_tick (link_tick),
    .px_valid  (stg_valid),
    .px_data   (stg_data),
    .px_eol    (stg_eol),
    .px_eof    (stg_eof),
    .px_ready  (pk_ready),
    .tap_data  (tap_data),
    .tap_dval  (tap_dval),
    .tap_lval  (tap_lval),
    .tap_fval  (tap_fval)
  );

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  sensor_avg_a: assert property (sen_vmode == MODE_AVG && sensor_bin_average == MODE_AVG)
    else $error("sensor bank left average mode");
  sensor_hfac_a: assert property (wr_cfg && bin_sel == ENG_SENSOR && fac_sen_ok(w_vf) |=> sen_hf == $past(w_vf))
    else $error("sensor horizontal factor did not follow");
  sensor_hmode_a: assert property (sen_hmode == sen_vmode)
    else $error("sensor horizontal mode differs");
  logic_hfac_a: assert property (fac_log_ok(log_hf))
    else $error("illegal logic horizontal factor");
  vert_fac_a: assert property (fac_log_ok(log_vf) && fac_sen_ok(sen_vf))
    else $error("illegal vertical factor");
  pix_bits_a: assert property (wr_sel |=> $stable(pix_bits) && bin_sel == $past(reg_wdata[0]))
    else $error("selector write misrouted");
  rate_wr_a: assert property (reg_wr && reg_addr == REG_LINK |=> link_clock_rate_select == $past(reg_wdata[0]))
    else $error("rate select not updated");
  clamp_max_a: assert property (in_ready && emit |=> stg_data <= ((PIX_W'(1) << pix_bits) - PIX_W'(1)))
    else $error("pixel above maximum code");
  pass_one_a: assert property (in_ready && emit && log_hf == FAC_1 && log_vf == FAC_1 && pix_bits == BITS_12
    |=> stg_data == $past(pix_data))
    else $error("unbinned pixel altered");
  sum_two_c: cover property (emit && log_hf == FAC_2 && log_hmode == MODE_SUM);
  avg_four_c: cover property (emit && log_vf == FAC_4 && log_vmode == MODE_AVG);
  stall_c: cover property (pix_valid && !in_ready);
endmodule

// file: pbt_grabber_model.sv
// frame grabber model: records tap words and framing at each link clock rise
`timescale 1ns/100ps
module pbt_grabber_model import pbt_pkg::*; (
  // link from the camera
  input  wire logic                      link_clk,
  input  wire logic [MAX_TAPS*PIX_W-1:0] tap_data,
  input  wire logic                      tap_dval,
  input  wire logic                      tap_lval,
  input  wire logic                      tap_fval
);
  logic [MAX_TAPS*PIX_W-1:0] words[$];  // data words received
  int                        lines = 0;  // falling line valid seen
  int                        frames = 0; // falling frame valid seen
  logic                      lval_q = 0; // qualifiers at the previous rise
  logic                      fval_q = 0;
  // outputs hold a whole link period, so each rise sees the word launched by the last one
  always @(posedge link_clk) begin
    if (tap_dval === 1'b1) words.push_back(tap_data);
    if (lval_q && tap_lval !== 1'b1) lines++;
    if (fval_q && tap_fval !== 1'b1) frames++;
    lval_q = tap_lval;
    fval_q = tap_fval;
  end
endmodule

// file: tb_pbt_binning_output.sv
// testbench of the binning, formatting and tap output stage
`timescale 1ns/100ps
module tb_pbt_binning_output import pbt_pkg::*; ();
  // design ports
  logic                      clk, reset_n, reg_wr, reg_rd, link_clk;
  logic [7:0]                reg_addr;
  logic [31:0]               reg_wdata, reg_rdata;
  logic [PIX_W-1:0]          pix_data;
  logic                      pix_valid, pix_eol, pix_eof, in_ready;
  logic [FAC_W-1:0]          sensor_bin_factor;
  logic                      sensor_bin_average, link_clock_rate_select;
  logic [MAX_TAPS*PIX_W-1:0] tap_data;
  logic                      tap_dval, tap_lval, tap_fval;
  // bench state
  logic [MAX_TAPS*PIX_W-1:0] want[$];       // expected tap words
  int                        err_count = 0;
  int                        compares = 0;

  pbt_binning_output u_dut (.*);
  pbt_grabber_model  u_grab (.link_clk(link_clk), .tap_data(tap_data), .tap_dval(tap_dval),
                             .tap_lval(tap_lval), .tap_fval(tap_fval));

  // system clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // link clock, 320 ns, phase unrelated to clk
  initial begin
    link_clk = 1'b0;
    #7;
    forever #160 link_clk = ~link_clk;
  end

  task automatic check(input string name, input logic [119:0] seen, input logic [119:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // a wait ran out of its bound
  task automatic fail_to();
    err_count++;
    end_of_test();
  endtask
  // one-cycle write, entered just after a rising edge; an idle edge follows so that
  // a following write never raises the strobe in the step that lowers it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // read, data judged mid-cycle after the strobe, where it stands
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check("reg", reg_rdata, exp);
    @(posedge clk);
  endtask
  // one pixel; valid is left high so back-to-back pixels never pulse it twice
  task automatic px(input logic [11:0] d, input logic eol, input logic eof);
    pix_valid <= 1'b1;
    pix_data <= d;
    pix_eol <= eol;
    pix_eof <= eof;
    @(negedge clk);
    for (int i = 0; i < 2000 && in_ready !== 1'b1; i++) @(negedge clk);
    if (in_ready !== 1'b1) fail_to();
    @(posedge clk);
  endtask
  // a 16 by 4 frame through the logic bank; expectation built from the binning arithmetic
  task automatic run(input int hf, vf, md, bits, taps, base);
    logic [119:0] w;
    int           s, v, k, l0, f0;
    wr(REG_BIN_CFG, 32'(vf << 8 | hf << 4 | md << 1 | md));
    wr(REG_FORMAT, 32'(taps << 8 | bits));
    want.delete();
    u_grab.words.delete();
    l0 = u_grab.lines;
    f0 = u_grab.frames;
    for (int r = 0; r < 4; r += vf) begin
      w = '0;
      k = 0;
      for (int c = 0; c < 16; c += hf) begin
        s = 0;
        for (int j = 0; j < hf * vf; j++) s += base + (r + j / hf) * 16 + c + j % hf;
        v = (md ? s / (hf * vf) : s) >> (12 - bits);
        if (v >= (1 << bits)) v = (1 << bits) - 1;
        w[k*12 +: 12] = 12'(v);
        k++;
        // a full group or the line end closes a word; short groups stay zero padded
        if (k == taps || c + hf == 16) begin
          want.push_back(w);
          w = '0;
          k = 0;
        end
      end
    end
    for (int i = 0; i < 64; i++) px(12'(base + i), i % 16 == 15, i == 63);
    pix_valid <= 1'b0;
    for (int t = 0; t < 4000 && u_grab.frames == f0; t++) @(posedge clk);
    if (u_grab.frames == f0) fail_to();
    check("lines", 120'(u_grab.lines - l0), 120'(4 / vf));
    check("words", 120'(u_grab.words.size()), 120'(want.size()));
    foreach (want[i]) check("tap word", u_grab.words[i], want[i]);
  endtask

  initial begin
    {reset_n, reg_wr, reg_rd, pix_valid, pix_eol, pix_eof} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    pix_data = 12'h000;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    check("sensor factor", 120'(sensor_bin_factor), 120'(FAC_1));
    check("sensor average", 120'(sensor_bin_average), 120'(1));
    rchk(REG_BIN_SEL, 32'h0000_0001);
    rchk(REG_FORMAT, 32'h0000_0208);
    rchk(8'h20, 32'h0);
    // grabber takes 85 MHz, so both rates are within its limit
    wr(REG_LINK, 32'h1);
    rchk(REG_LINK, 32'h1);
    check("rate", 120'(link_clock_rate_select), 120'(RATE_65));
    wr(REG_LINK, 32'h0);
    rchk(REG_LINK, 32'h0);
    check("rate", 120'(link_clock_rate_select), 120'(RATE_85));
    // sensor bank: sum asked, average forced, h follows v
    wr(REG_BIN_SEL, 32'h0);
    wr(REG_BIN_CFG, 32'h0000_0310);
    rchk(REG_BIN_CFG, 32'h0000_0333);
    check("sensor factor", 120'(sensor_bin_factor), 120'(FAC_3));
    wr(REG_BIN_CFG, 32'h0000_0200);
    rchk(REG_BIN_CFG, 32'h0000_0333);
    // logic bank x4 on top of sensor x3 gives twelve
    wr(REG_BIN_SEL, 32'h1);
    wr(REG_BIN_CFG, 32'h0000_0444);
    rchk(REG_STATUS, 32'h0000_cc00);
    // bits 3:2 are not stored, so they read back as zero
    wr(REG_BIN_CFG, 32'h0000_0434);
    rchk(REG_BIN_CFG, 32'h0000_0440);
    wr(REG_BIN_SEL, 32'h0);
    wr(REG_BIN_CFG, 32'h0000_0100);
    wr(REG_BIN_SEL, 32'h1);
    // every tap geometry unbinned, then binned runs mixing factors, modes and widths
    run(1, 1, 0, 12, 2, 0);
    run(1, 1, 0, 12, 4, 0);
    run(1, 1, 0, 12, 8, 0);
    run(1, 1, 0, 12, 10, 0);
    run(2, 1, 0, 12, 2, 12'h900);
    run(2, 2, 1, 12, 4, 16);
    run(1, 2, 0, 8, 8, 12'h400);
    run(1, 4, 1, 12, 2, 0);
    run(4, 1, 1, 10, 10, 40);
    rchk(REG_STATUS, 32'h0009_1400);
    end_of_test();
  end
endmodule
